// [shared/egx_pkg.sv]
// Constants for the encrypted guest exit classifier
package egx_pkg;
   // Register offsets (byte addresses)
   localparam logic [7:0] OFF_ENC_CTRL = 8'h00;
   localparam logic [7:0] OFF_BRV_CTRL = 8'h04;
   localparam logic [7:0] OFF_GUEST_ADDRESS_SPACE_ID = 8'h08;
   localparam logic [7:0] OFF_FEATURE_LEAF = 8'h0C;
   localparam logic [7:0] OFF_MIN_ADDRESS_SPACE_ID = 8'h10;
   localparam logic [7:0] OFF_STATUS = 8'h14;
   localparam logic [7:0] OFF_LAST_EXIT = 8'h18;
   // Encryption and branch control word field positions
   localparam int BIT_ENC_VIRT = 1;
   localparam int BIT_ENC_REGS = 2;
   localparam int BIT_FORCED = 5;
   localparam int BIT_BRV = 0;
   // Feature leaf bits
   localparam int FEAT_ENC_VIRT = 1;
   localparam int FEAT_ENC_REGS = 3;
   localparam int FEAT_FORCED = 16;
   // Status bits
   localparam int ST_FORCED_ACT = 0;
   localparam int ST_REGS_ACT = 1;
   localparam int ST_GUEST_RUN = 2;
   localparam int ST_ADDRESS_SPACE_ID_LOW = 3;
   localparam int ST_LAST_AUTO = 4;
   // Reset values and widths
   localparam logic [31:0] RST_ZERO = 32'h0000_0000;
   localparam int ADDRESS_SPACE_ID_W = 12;
   localparam logic [11:0] MIN_ADDRESS_SPACE_ID_VAL = 12'h001;
   localparam int GPA_W = 52;
   localparam int CBIT_POS = 47;
   // Exit codes
   localparam logic [11:0] EX_MC = 12'h052;
   localparam logic [11:0] EX_INTR_LO = 12'h060;
   localparam logic [11:0] EX_INTR_HI = 12'h064;
   localparam logic [11:0] EX_PAUSE = 12'h077;
   localparam logic [11:0] EX_HLT = 12'h078;
   localparam logic [11:0] EX_SHUTDOWN = 12'h07F;
   localparam logic [11:0] EX_FEAT_TRAP = 12'h08F;
   localparam logic [7:0] EX_CTRL_TRAP_HI = 8'h09;
   localparam logic [11:0] EX_NESTED_FAULT = 12'h400;
   localparam logic [11:0] EX_GUEST_EXIT = 12'h403;
   localparam logic [63:0] EX_INVALID = 64'hFFFF_FFFF_FFFF_FFFF;
   localparam logic [63:0] EX_BUSY = 64'hFFFF_FFFF_FFFF_FFFE;
   localparam int FAULT_RSVD_BIT = 3;
   localparam logic [7:0] VC_VECTOR = 8'h1D;
   // Run states
   typedef enum logic [1:0] {
      ST_HOST = 2'b01,
      ST_GUEST = 2'b10
   } egx_state_t;
endpackage

// [logic/egx_classifier.sv]
// Encrypted guest exit classifier with APB control registers
//
// Summary of operation
// (RULE1) Forced encryption only with encryption, no register encryption
// (RULE2) Forced encryption makes select bit one
// (RULE3) Nested lookup uses address without select bit
// (RULE4) Feature leaf reports forced encryption support
// (RULE5) Feature leaf reports register encryption support
// (RULE6) Hypervisor sets register, encryption, branch bits
// (RULE7) Report minimum id for plain encrypted guests
// (RULE8) Hypervisor prepares initial encrypted state image
// (RULE9) Save on exit, restore only on entry
// (RULE10) Save structure uses guest key, integrity; save_guest_key and save_integrity are low in the state_save cycle
// (RULE11) Exit taken only when intercept bit set; code also takes guest exit without it under register encryption
// (RULE12) Automatic exits report reason, others raise exception
// (RULE13) Asynchronous automatic exits never advance pointer
// (RULE14) Instruction and trap exits advance pointer
// (RULE15) Nested fault automatic only without reserved error
// (RULE16) Invalid state minus one, busy minus two
// (RULE17) Hypervisor marks emulated I/O pages reserved
// (RULE18) No instruction bytes saved under register encryption
// (RULE19) Exception precise, fixed vector, error equals code
//
// Decided for this implementation: the register offsets and register access over APB.
module egx_classifier
   import egx_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Guest entry request
   input wire logic guest_entry,
   input wire logic entry_invalid,
   input wire logic entry_busy,
   // Guest exit event from the core
   input wire logic exit_req,
   input wire logic [11:0] exit_code,
   input wire logic exit_intercept,
   input wire logic [31:0] exit_fault_code,
   input wire logic [3:0] exit_insn_len,
   input wire logic [63:0] guest_rip,
   // Guest memory reference
   input wire logic [GPA_W-1:0] mem_gpa,
   input wire logic mem_cbit,
   output logic mem_eff_cbit,
   output logic [GPA_W-1:0] nested_lookup_gpa,
   // Automatic exit to the hypervisor
   output logic ae_valid,
   output logic [63:0] ae_exit_reason,
   output logic rip_adv_valid,
   output logic [63:0] rip_next,
   output logic insn_bytes_save_en,
   // Guest communication exception
   output logic vc_valid,
   output logic [7:0] vc_vector,
   output logic [63:0] vc_error_code,
   // State save and restore control
   output logic state_save,
   output logic state_restore,
   output logic save_guest_key,
   output logic save_integrity,
   output logic guest_active
);

   ////////////////////////////////////////////////////////////////////////
   // Register storage
   logic [31:0] enc_ctrl_reg;
   logic [31:0] brv_ctrl_reg;
   logic [ADDRESS_SPACE_ID_W-1:0] address_space_id_reg;
   logic [31:0] last_exit_reg;
   logic last_auto_reg;
   egx_state_t state_reg;
   // Modes latched at guest entry, so mid-run writes do not disturb a guest
   logic run_virt_reg;
   logic run_regs_reg;
   logic run_forced_reg;

   ////////////////////////////////////////////////////////////////////////
   // APB decode
   wire logic apb_access = psel & penable;
   wire logic hit_enc = (paddr[7:0] == OFF_ENC_CTRL);
   wire logic hit_brv = (paddr[7:0] == OFF_BRV_CTRL);
   wire logic hit_address_space_id = (paddr[7:0] == OFF_GUEST_ADDRESS_SPACE_ID);
   wire logic hit_feat = (paddr[7:0] == OFF_FEATURE_LEAF);
   wire logic hit_min = (paddr[7:0] == OFF_MIN_ADDRESS_SPACE_ID);
   wire logic hit_stat = (paddr[7:0] == OFF_STATUS);
   wire logic hit_last = (paddr[7:0] == OFF_LAST_EXIT);
   wire logic high_zero = (paddr[31:8] == 24'h00_0000) & (paddr[1:0] == 2'h0);
   wire logic hit_rw = high_zero & (hit_enc | hit_brv | hit_address_space_id);
   wire logic hit_ro = high_zero & (hit_feat | hit_min | hit_stat | hit_last);
   wire logic apb_wr = apb_access & pwrite & hit_rw;
   wire logic [31:0] wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
   // Only the documented control bits are writable
   wire logic [31:0] enc_bits = (32'h1 << BIT_ENC_VIRT) | (32'h1 << BIT_ENC_REGS)
      | (32'h1 << BIT_FORCED);
   wire logic [31:0] enc_next = (enc_ctrl_reg & ~(wmask & enc_bits))
      | (pwdata & wmask & enc_bits);
   wire logic [31:0] brv_bits = 32'h1 << BIT_BRV;
   wire logic [31:0] brv_next = (brv_ctrl_reg & ~(wmask & brv_bits))
      | (pwdata & wmask & brv_bits);
   wire logic [31:0] address_space_id_wide = {{(32-ADDRESS_SPACE_ID_W){1'b0}}, address_space_id_reg};
   wire logic [31:0] address_space_id_next = (address_space_id_wide & ~wmask) | (pwdata & wmask);

   // Slave answers in the first access cycle; unmapped or writes to read-only fail
   assign pready = 1'b1;
   assign pslverr = apb_access & ~(hit_rw | (hit_ro & ~pwrite));

   ////////////////////////////////////////////////////////////////////////
   // Configuration decode
   wire logic cfg_virt = enc_ctrl_reg[BIT_ENC_VIRT];
   wire logic cfg_regs = enc_ctrl_reg[BIT_ENC_REGS];
   // (RULE1) forced bit gating
   wire logic cfg_forced = enc_ctrl_reg[BIT_FORCED] & cfg_virt & ~cfg_regs;
   // (RULE7) low id check
   wire logic address_space_id_low = cfg_virt & ~cfg_regs & (address_space_id_reg < MIN_ADDRESS_SPACE_ID_VAL);
   wire logic running = (state_reg == ST_GUEST);

   // Feature leaf and status words
   // (RULE4) forced support bit
   // (RULE5) register encryption bit
   wire logic [31:0] feat_word = (32'h1 << FEAT_FORCED) | (32'h1 << FEAT_ENC_REGS)
      | (32'h1 << FEAT_ENC_VIRT);
   wire logic [31:0] stat_word = {27'h000_0000, last_auto_reg, address_space_id_low, running,
      run_regs_reg & running, run_forced_reg & running};

   // Read data mux
   wire logic [31:0] rd_mux = !high_zero ? RST_ZERO :
      hit_enc ? enc_ctrl_reg :
      hit_brv ? brv_ctrl_reg :
      hit_address_space_id ? address_space_id_wide :
      hit_feat ? feat_word :
      hit_min ? {20'h0_0000, MIN_ADDRESS_SPACE_ID_VAL} :
      hit_stat ? stat_word :
      hit_last ? last_exit_reg : RST_ZERO;
   // Read data loads at the end of setup so it stands through the access phase;
   // a status change during the access cycle shows on the next read
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prdata <= RST_ZERO;
      end else begin
         prdata <= (psel & ~penable & ~pwrite) ? rd_mux : RST_ZERO;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Exit classification
   wire logic is_mc = (exit_code == EX_MC);
   wire logic is_intr = (exit_code >= EX_INTR_LO) & (exit_code <= EX_INTR_HI);
   wire logic is_shut = (exit_code == EX_SHUTDOWN);
   wire logic is_pause = (exit_code == EX_PAUSE);
   wire logic is_hlt = (exit_code == EX_HLT);
   wire logic is_feat_trap = (exit_code == EX_FEAT_TRAP);
   wire logic is_ctrl_trap = (exit_code[11:4] == EX_CTRL_TRAP_HI);
   wire logic is_gexit = (exit_code == EX_GUEST_EXIT);
   wire logic is_npf = (exit_code == EX_NESTED_FAULT);
   // (RULE14) pointer advance set
   wire logic is_adv = is_pause | is_hlt | is_feat_trap | is_ctrl_trap | is_gexit;
   // (RULE15) reserved bit split
   wire logic npf_auto = is_npf & ~exit_fault_code[FAULT_RSVD_BIT];
   // (RULE13) asynchronous automatic set
   wire logic is_async = is_mc | is_intr | is_shut;
   wire logic is_auto = is_async | is_adv | npf_auto;
   // (RULE11) intercept gating; guest exit instruction needs no intercept under register encryption
   wire logic ex_taken = running & exit_req & (exit_intercept | (run_regs_reg & is_gexit));
   // (RULE12) automatic versus exception split
   wire logic take_ae = ex_taken & (~run_regs_reg | is_auto);
   wire logic take_vc = ex_taken & run_regs_reg & ~is_auto;

   // Entry checks
   wire logic entry_req = (state_reg == ST_HOST) & guest_entry;
   wire logic entry_fail = entry_req & (entry_invalid | entry_busy);
   wire logic entry_ok = entry_req & ~entry_invalid & ~entry_busy;
   // (RULE16) invalid wins over busy
   wire logic [63:0] fail_reason = entry_invalid ? EX_INVALID : EX_BUSY;

   // Next run state
   egx_state_t state_next;
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_HOST: begin
            if (entry_ok) begin
               state_next = ST_GUEST;
            end
         end
         ST_GUEST: begin
            if (take_ae) begin
               state_next = ST_HOST;
            end
         end
         default: begin
            state_next = ST_HOST;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Register writes from software
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         enc_ctrl_reg <= RST_ZERO;
         brv_ctrl_reg <= RST_ZERO;
         address_space_id_reg <= '0;
      end else if (apb_wr) begin
         if (hit_enc) enc_ctrl_reg <= enc_next;
         if (hit_brv) brv_ctrl_reg <= brv_next;
         if (hit_address_space_id) address_space_id_reg <= address_space_id_next[ADDRESS_SPACE_ID_W-1:0];
      end
   end

   // Run state and modes in effect for the running guest
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg <= ST_HOST;
         run_virt_reg <= 1'b0;
         run_regs_reg <= 1'b0;
         run_forced_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         if (entry_ok) begin
            run_virt_reg <= cfg_virt;
            run_regs_reg <= cfg_regs & cfg_virt;
            run_forced_reg <= cfg_forced;
         end
      end
   end

   // Hypervisor-visible exit reports
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ae_valid <= 1'b0;
         ae_exit_reason <= 64'h0;
         rip_adv_valid <= 1'b0;
         rip_next <= 64'h0;
         insn_bytes_save_en <= 1'b0;
         last_exit_reg <= RST_ZERO;
         last_auto_reg <= 1'b0;
      end else begin
         ae_valid <= take_ae | entry_fail;
         rip_adv_valid <= 1'b0;
         insn_bytes_save_en <= 1'b0;
         if (entry_fail) begin
            ae_exit_reason <= fail_reason;
            last_exit_reg <= fail_reason[31:0];
            last_auto_reg <= 1'b1;
         end else if (ex_taken) begin
            last_exit_reg <= {20'h0_0000, exit_code};
            last_auto_reg <= take_ae;
            if (take_ae) begin
               ae_exit_reason <= {52'h0_0000_0000_0000, exit_code};
               // (RULE14) advance past instruction
               rip_adv_valid <= run_regs_reg & is_adv;
               rip_next <= guest_rip + {60'h0, exit_insn_len};
               // (RULE18) no instruction bytes
               insn_bytes_save_en <= is_npf & ~run_regs_reg;
            end
         end
      end
   end

   // Guest communication exception, delivered inside the guest
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         vc_valid <= 1'b0;
         vc_vector <= 8'h00;
         vc_error_code <= 64'h0;
      end else begin
         vc_valid <= take_vc;
         if (take_vc) begin
            // (RULE19) fixed vector and code
            vc_vector <= VC_VECTOR;
            vc_error_code <= {52'h0_0000_0000_0000, exit_code};
         end
      end
   end

   // Register state protection across world switches
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_save <= 1'b0;
         state_restore <= 1'b0;
         save_guest_key <= 1'b0;
         save_integrity <= 1'b0;
      end else begin
         // (RULE9) save on exit, restore on entry
         state_save <= take_ae & run_regs_reg;
         state_restore <= entry_ok & cfg_regs & cfg_virt;
         // (RULE10) guest key with integrity only while state_next is ST_GUEST; both low with state_save
         save_guest_key <= (state_next == ST_GUEST) ? (entry_ok ? cfg_regs & cfg_virt
            : run_regs_reg) : 1'b0;
         save_integrity <= (state_next == ST_GUEST) ? (entry_ok ? cfg_regs & cfg_virt
            : run_regs_reg) : 1'b0;
      end
   end

   // Guest memory path, one cycle of latency
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mem_eff_cbit <= 1'b0;
         nested_lookup_gpa <= '0;
      end else begin
         // (RULE2) select bit forced
         mem_eff_cbit <= mem_cbit | (running & run_forced_reg);
         // (RULE3) strip select bit
         nested_lookup_gpa <= mem_gpa & ~({{(GPA_W-1){1'b0}}, 1'b1} << CBIT_POS);
      end
   end

   assign guest_active = running;

endmodule // egx_classifier

// [test/egx_chk.sv]
// Port checker for the encrypted guest exit classifier
module egx_chk
   import egx_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Memory reference
   input wire logic [GPA_W-1:0] mem_gpa,
   input wire logic [GPA_W-1:0] nested_lookup_gpa,
   // Entry and exit causes
   input wire logic guest_entry,
   input wire logic entry_invalid,
   input wire logic exit_req,
   input wire logic [11:0] exit_code,
   input wire logic exit_intercept,
   input wire logic [31:0] exit_fault_code,
   input wire logic [3:0] exit_insn_len,
   input wire logic [63:0] guest_rip,
   // Results
   input wire logic ae_valid,
   input wire logic [63:0] ae_exit_reason,
   input wire logic rip_adv_valid,
   input wire logic [63:0] rip_next,
   input wire logic insn_bytes_save_en,
   input wire logic vc_valid,
   input wire logic [7:0] vc_vector,
   input wire logic [63:0] vc_error_code,
   input wire logic save_guest_key,
   input wire logic guest_active
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////////
   // Past-reset guards keep the first edge after release quiet
   a_strip_select: assert property (
      !$past(rst) |-> nested_lookup_gpa == ($past(mem_gpa) & ~(52'h1 << CBIT_POS)))
      else $error("nested address keeps select bit");
   a_rip_step: assert property (
      rip_adv_valid |-> ae_valid && rip_next == $past(guest_rip) + $past(exit_insn_len))
      else $error("pointer advance wrong");
   a_async_norip: assert property (
      ae_valid && ae_exit_reason inside {64'h52, [64'h60:64'h64], 64'h7F} |-> !rip_adv_valid)
      else $error("asynchronous exit advanced pointer");
   a_vc_fields: assert property (
      vc_valid |-> vc_vector == VC_VECTOR && vc_error_code == {52'h0, $past(exit_code)})
      else $error("exception vector or error code wrong");
   a_intercept_gate: assert property (
      !$past(rst) && $past(exit_req) && !$past(exit_intercept) && $past(exit_code) != EX_GUEST_EXIT
      |-> !ae_valid && !vc_valid) else $error("exit taken without intercept");
   a_npf_reserved: assert property (
      $past(exit_req) && $past(exit_intercept) && $past(save_guest_key) && $past(guest_active)
      && $past(exit_code) == EX_NESTED_FAULT && $past(exit_fault_code[FAULT_RSVD_BIT])
      |-> vc_valid && !ae_valid) else $error("reserved nested fault not routed to guest");
   a_no_insn_bytes: assert property (
      insn_bytes_save_en |-> !$past(save_guest_key)) else $error("bytes saved when encrypted");
   a_invalid_entry: assert property (
      !$past(rst) && $past(guest_entry) && !$past(guest_active) && $past(entry_invalid)
      |-> ae_valid && ae_exit_reason == EX_INVALID && !rip_adv_valid)
      else $error("invalid entry not reported");
   // Main scenarios reached
   c_vc: cover property (vc_valid);
   c_rip: cover property (rip_adv_valid);
   c_busy: cover property (ae_valid && ae_exit_reason == EX_BUSY);
endmodule // egx_chk

bind egx_classifier egx_chk u_chk (.clk, .rst, .mem_gpa, .nested_lookup_gpa, .guest_entry,
   .entry_invalid, .exit_req, .exit_code, .exit_intercept, .exit_fault_code, .exit_insn_len,
   .guest_rip, .ae_valid, .ae_exit_reason, .rip_adv_valid, .rip_next, .insn_bytes_save_en,
   .vc_valid, .vc_vector, .vc_error_code, .save_guest_key, .guest_active);

// [test/egx_hv_model.sv]
// Hypervisor model: APB master that programs the guest control block
module egx_hv_model
   import egx_pkg::*;
(
   // Clock
   input wire logic clk,
   // APB master
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [31:0] paddr,
   output logic [31:0] pwdata,
   output logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
   // One transfer, held until pready is seen high at an edge
   task automatic xfer(input logic w, input logic [31:0] a, d, output logic [31:0] r,
      output logic e);
      @(posedge clk);
      {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, d, 4'hF};
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      r = prdata;
      e = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   task automatic setup_guest(input logic [31:0] enc, input logic [11:0] id);
      logic [31:0] r;
      logic e;
      xfer(1'b1, {24'h0, OFF_ENC_CTRL}, enc, r, e);
      xfer(1'b1, {24'h0, OFF_BRV_CTRL}, {31'h0, enc[BIT_ENC_REGS]}, r, e);
      xfer(1'b1, {24'h0, OFF_GUEST_ADDRESS_SPACE_ID}, {20'h0, id}, r, e);
   endtask
endmodule // egx_hv_model

// [test/encrypted_guest_exit_classifier_test.sv]
// Self-checking bench for the encrypted guest exit classifier
module encrypted_guest_exit_classifier_test
   import egx_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst, psel, penable, pwrite, pready, pslverr, guest_entry, entry_invalid;
   logic entry_busy, exit_req, exit_intercept, mem_cbit, mem_eff_cbit, ae_valid, er;
   logic rip_adv_valid, insn_bytes_save_en, vc_valid, state_save, state_restore;
   logic save_guest_key, save_integrity, guest_active, renc;
   logic [31:0] paddr, pwdata, prdata, exit_fault_code, rd;
   logic [3:0] pstrb, exit_insn_len;
   logic [11:0] exit_code;
   logic [63:0] guest_rip, ae_exit_reason, rip_next, vc_error_code;
   logic [GPA_W-1:0] mem_gpa, nested_lookup_gpa;
   logic [7:0] vc_vector;
   int n_fail, check_count, cyc;
   int codes[$] = '{12'h052, 12'h060, 12'h061, 12'h062, 12'h063, 12'h064, 12'h07F, 12'h077,
      12'h078, 12'h08F, 12'h090, 12'h09F, 12'h403, 12'h07B, 12'h400};
   egx_classifier dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
      .prdata, .pready, .pslverr, .guest_entry, .entry_invalid, .entry_busy, .exit_req,
      .exit_code, .exit_intercept, .exit_fault_code, .exit_insn_len, .guest_rip, .mem_gpa,
      .mem_cbit, .mem_eff_cbit, .nested_lookup_gpa, .ae_valid, .ae_exit_reason,
      .rip_adv_valid, .rip_next, .insn_bytes_save_en, .vc_valid, .vc_vector, .vc_error_code,
      .state_save, .state_restore, .save_guest_key, .save_integrity, .guest_active);
   egx_hv_model hv (.clk, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
      .pready, .pslverr);
   ////////////////////////////////////////////////////////////////////////////
   // Reference classification, kept apart from the design's decode
   function automatic bit is_adv(int c);
      return c == 12'h077 || c == 12'h078 || c == 12'h403 || (c >= 12'h08F && c <= 12'h09F);
   endfunction
   function automatic bit is_ae(int c, int f);
      return is_adv(c) || c == 12'h052 || (c >= 12'h060 && c <= 12'h064) || c == 12'h07F
         || (c == 12'h400 && f[3] == 1'b0);
   endfunction
   task automatic chk(input logic [63:0] got, exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic close_out();
      if (n_fail == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Register read with expected data and error flag
   task automatic reg_rd(input logic [7:0] a, input logic [31:0] d, input logic e);
      hv.xfer(1'b0, {24'h0, a}, 32'h0, rd, er);
      chk(rd, d);
      chk(er, e);
   endtask
   // Guest entry; a failed check must leave the guest in host state
   task automatic enter(input logic inv, bsy);
      @(posedge clk);
      {guest_entry, entry_invalid, entry_busy} <= {1'b1, inv, bsy};
      @(posedge clk);
      guest_entry <= 1'b0;
      #1;
      chk(guest_active, !(inv | bsy));
      chk(state_restore, !(inv | bsy) && renc);
      chk(save_guest_key, !(inv | bsy) && renc);
      chk(ae_valid, inv | bsy);
      if (inv | bsy) chk(ae_exit_reason, inv ? EX_INVALID : EX_BUSY);
   endtask
   // Exit event, judged against the reference classification
   task automatic ex(input logic [11:0] c, input logic icpt, input logic [31:0] f);
      logic tk, au;
      @(posedge clk);
      {exit_req, exit_code, exit_intercept, exit_fault_code} <= {1'b1, c, icpt, f};
      exit_insn_len <= 4'($urandom_range(15, 1));
      guest_rip <= {$urandom, $urandom};
      @(posedge clk);
      exit_req <= 1'b0;
      #1;
      tk = icpt || (renc && c == EX_GUEST_EXIT);
      au = !renc || is_ae(c, f);
      chk(ae_valid, tk && au);
      chk(vc_valid, tk && !au);
      chk(guest_active, !(tk && au));
      if (tk && au) chk(ae_exit_reason, {52'h0, c});
      if (tk && !au) chk(vc_error_code, {52'h0, c});
      chk(rip_adv_valid, renc && tk && au && is_adv(c));
      if (rip_adv_valid === 1'b1) chk(rip_next, guest_rip + exit_insn_len);
      chk(insn_bytes_save_en, tk && !renc && c == EX_NESTED_FAULT);
      chk(state_save, tk && au && renc);
      chk(save_integrity, renc && !(tk && au));
   endtask
   // Memory reference with select bit c
   task automatic mref(input logic c, e);
      logic [GPA_W-1:0] g;
      g = GPA_W'({$urandom, $urandom});
      @(posedge clk);
      {mem_gpa, mem_cbit} <= {g, c};
      @(posedge clk);
      #1;
      chk(mem_eff_cbit, e);
      chk(nested_lookup_gpa, g & ~(52'h1 << CBIT_POS));
   endtask
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // Hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         $display("ERROR %0t timeout", $time);
         close_out();
      end
   end
   initial begin
      {rst, renc, n_fail, check_count, cyc} = {2'b10, 96'h0};
      {guest_entry, entry_invalid, entry_busy, exit_req, exit_intercept, mem_cbit} = '0;
      {exit_code, exit_fault_code, exit_insn_len, guest_rip, mem_gpa} = '0;
      void'($urandom(62));
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      reg_rd(OFF_FEATURE_LEAF, 32'h0001_000A, 1'b0);
      reg_rd(OFF_MIN_ADDRESS_SPACE_ID, {20'h0, MIN_ADDRESS_SPACE_ID_VAL}, 1'b0);
      reg_rd(8'h1C, 32'h0, 1'b1);
      hv.xfer(1'b1, {24'h0, OFF_MIN_ADDRESS_SPACE_ID}, 32'hFFFF_FFFF, rd, er);
      chk(er, 1'b1);
      // Plain encrypted guest with an id below the minimum is flagged
      hv.setup_guest(32'h0000_0002, 12'h000);
      reg_rd(OFF_STATUS, 32'h0000_0008, 1'b0);
      hv.setup_guest(32'h0000_0022, 12'h005);
      enter(1'b0, 1'b0);
      mref(1'b0, 1'b1);
      reg_rd(OFF_STATUS, 32'h0000_0005, 1'b0);
      ex(EX_NESTED_FAULT, 1'b1, 32'h0);
      reg_rd(OFF_LAST_EXIT, 32'h0000_0400, 1'b0);
      reg_rd(OFF_STATUS, 32'h0000_0010, 1'b0);
      // control block and image ready before first register-encrypted entry
      hv.setup_guest(32'h0000_0026, 12'h001);
      renc = 1'b1;
      enter(1'b0, 1'b0);
      mref(1'b0, 1'b0);
      mref(1'b1, 1'b1);
      foreach (codes[i]) begin
         ex(12'(codes[i]), 1'b1, 32'h0);
         if (guest_active !== 1'b1) enter(1'b0, 1'b0);
      end
      ex(EX_NESTED_FAULT, 1'b1, 32'h8);
      ex(12'h07B, 1'b0, 32'h0);
      ex(EX_GUEST_EXIT, 1'b0, 32'h0);
      enter(1'b1, 1'b0);
      enter(1'b0, 1'b1);
      enter(1'b1, 1'b1);
      close_out();
   end
endmodule // encrypted_guest_exit_classifier_test
